// File: hw/swb_pkg.sv
// Purpose: Shared constants for the single-wire read-byte and triplet engine
// Assumes: 25 MHz system clock; timings given in ns or ps then converted
// Notes: Register offsets are word indexes on a plain port; field positions are bit indexes

package swb_pkg;
	// Command codes seen on the serial host port
	localparam logic [7:0] CMD_READ_BYTE = 8'h96;
	localparam logic [7:0] CMD_TRIPLET = 8'h78;

	// System clock period
	localparam int CLK_NS = 40;
	localparam int CLK_PS = 40000;

	// Latest start of line activity after the host clock edge
	localparam int START_MAX_PS = 262500;
	localparam int START_MAX_CYC = (START_MAX_PS / CLK_PS < 1) ? 1 : START_MAX_PS / CLK_PS;

	// Slot timings, standard speed (ns)
	localparam int SLOT_STD_NS = 70000;
	localparam int LOW1_STD_NS = 6000;
	localparam int LOW0_STD_NS = 60000;
	localparam int MSR_STD_NS = 15000;
	// Slot timings, high speed (ns)
	localparam int SLOT_OD_NS = 10000;
	localparam int LOW1_OD_NS = 1000;
	localparam int LOW0_OD_NS = 7500;
	localparam int MSR_OD_NS = 2000;

	// Counter width for slot timing
	localparam int CNT_W = 12;

	// Least times round up to whole cycles
	localparam logic [CNT_W-1:0] SLOT_STD_CYC = CNT_W'((SLOT_STD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] LOW1_STD_CYC = CNT_W'((LOW1_STD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] LOW0_STD_CYC = CNT_W'((LOW0_STD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] MSR_STD_CYC = CNT_W'((MSR_STD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] SLOT_OD_CYC = CNT_W'((SLOT_OD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] LOW1_OD_CYC = CNT_W'((LOW1_OD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] LOW0_OD_CYC = CNT_W'((LOW0_OD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] MSR_OD_CYC = CNT_W'((MSR_OD_NS + CLK_NS - 1) / CLK_NS);

	// Index of the last slot per command
	localparam logic [2:0] LAST_SLOT_RB = 3'h7;
	localparam logic [2:0] LAST_SLOT_TRIP = 3'h2;

	// Register indexes on the plain register port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_RDATA = 4'h2;
	localparam logic [3:0] REG_RPTR = 4'h3;

	// Control fields
	localparam int CTRL_OD_BIT = 0;
	localparam int CTRL_APU_BIT = 1;
	localparam int CTRL_SPU_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_SBR_BIT = 1;
	localparam int ST_TSB_BIT = 2;
	localparam int ST_DIR_BIT = 3;
	localparam int ST_FVALID_BIT = 4;
	localparam int ST_FFULL_BIT = 5;

	// Read pointer values
	localparam logic RP_STATUS = 1'b0;
	localparam logic RP_DATA = 1'b1;

	// Result queue depth
	localparam int FIFO_DEPTH = 8;
endpackage : swb_pkg

// File: hw/swb_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, at least 2
// Notes: Output word is shown from the array while out_valid is high

`timescale 1ns/1ns

module swb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Refuse depths the pointer arithmetic cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("swb_fifo: DEPTH must be a power of two of at least 2");
	end

	// Storage and pointers with one wrap bit
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_ptr_q;
	logic [AW:0] rd_ptr_q;

	// Full when pointers differ only in wrap bit
	assign in_ready = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
	assign out_valid = (wr_ptr_q != rd_ptr_q);
	assign out_data = mem_q[rd_ptr_q[AW-1:0]];

	// Write side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
		end else if (in_valid && in_ready) begin
			mem_q[wr_ptr_q[AW-1:0]] <= in_data;
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	// Read side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_ptr_q <= '0;
		end else if (out_valid && out_ready) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end
endmodule : swb_fifo

// File: hw/swb_core.sv
// Purpose: Serial host command front end and single-wire slot engine
// Assumes: scl, sda and line input are asynchronous; read results drain by register port
// Notes: Only write frames are served on the serial port; reads are not acknowledged
//
// Chosen here: the address map and the strobed register port.

`timescale 1ns/1ns

module swb_core
	import swb_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h2A,
	parameter int QDEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial host pins, open drain data
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Single-wire line, open drain
	input wire logic owl_in,
	output logic owl_out,
	output logic owl_oe_n,
	output logic owl_pullup,
	output logic line_busy_flag,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);
	// Refuse a queue the FIFO cannot build
	if (QDEPTH < 2) begin : g_bad_q
		$error("swb_core: QDEPTH must be at least 2");
	end

	typedef enum logic [3:0] {
		I_IDLE = 4'b0001, I_BITS = 4'b0010, I_ACK = 4'b0100, I_SKIP = 4'b1000
	} swb_i2c_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b001, S_LOW = 3'b010, S_HIGH = 3'b100
	} swb_slot_t;

	// Pick standard or high-speed cycle count
	function automatic logic [CNT_W-1:0] tsel(input logic od, input logic [CNT_W-1:0] std,
		input logic [CNT_W-1:0] fast);
		tsel = od ? fast : std;
	endfunction : tsel

	// Synchronisers: stage 0 feeds only stage 1, stage 2 is edge history
	logic [2:0] scl_sq;
	logic [2:0] sda_sq;
	logic [1:0] owl_sq;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_sq <= 3'h7;
			sda_sq <= 3'h7;
			owl_sq <= 2'h3;
		end else begin
			scl_sq <= {scl_sq[1:0], scl};
			sda_sq <= {sda_sq[1:0], sda_in};
			owl_sq <= {owl_sq[0], owl_in};
		end
	end

	// Edge and condition decode on settled samples
	logic scl_rise, scl_fall, i2c_start, i2c_stop, owl_s;
	assign scl_rise = scl_sq[1] && !scl_sq[2];
	assign scl_fall = !scl_sq[1] && scl_sq[2];
	assign i2c_start = scl_sq[1] && scl_sq[2] && !sda_sq[1] && sda_sq[2];
	assign i2c_stop = scl_sq[1] && scl_sq[2] && sda_sq[1] && !sda_sq[2];
	assign owl_s = owl_sq[1];

	// Frame state
	swb_i2c_t i_state_q;
	logic [3:0] bit_cnt_q;     // Bits of current byte
	logic [6:0] sh_q;          // Incoming bits, MS first
	logic [1:0] byte_q;        // 0 address, 1 code, 2 parameter, 3 extra
	logic ack_q;               // Acknowledge decision for this byte
	logic trip_ok_q;           // Triplet accepted, expecting direction
	logic rb_pend_q;           // Read-byte accepted, start after ack
	logic v_q;                 // Direction value bit
	logic rb_go_q, trip_go_q;  // One-cycle start pulses
	logic accept_q;            // Command accepted pulse
	logic sda_oe_n_q;
	logic busy_q;
	logic fifo_in_ready;
	logic [7:0] rx_byte;
	assign rx_byte = {sh_q, sda_sq[1]};

	// Serial frame receiver and command acceptance
	always_ff @(posedge clk) begin
		rb_go_q <= 1'b0;
		trip_go_q <= 1'b0;
		accept_q <= 1'b0;
		if (!rst_n) begin
			i_state_q <= I_IDLE;
			bit_cnt_q <= 4'h0;
			sh_q <= 7'h00;
			byte_q <= 2'h0;
			ack_q <= 1'b0;
			trip_ok_q <= 1'b0;
			rb_pend_q <= 1'b0;
			v_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (i2c_start) begin
			// Start or repeated start opens a new frame
			i_state_q <= I_BITS;
			bit_cnt_q <= 4'h0;
			byte_q <= 2'h0;
			trip_ok_q <= 1'b0;
			rb_pend_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (i2c_stop) begin
			i_state_q <= I_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			unique case (i_state_q)
				I_IDLE, I_SKIP: begin
					// Wait for next start
				end
				I_BITS: begin
					if (scl_rise && bit_cnt_q < 4'h8) begin
						sh_q <= rx_byte[6:0];
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == 4'h0 && byte_q == 2'h2) begin
							v_q <= sda_sq[1];
						end
						if (bit_cnt_q == 4'h7) begin
							unique case (byte_q)
								2'h0: ack_q <= (rx_byte[7:1] == SLAVE_ADDR) && !rx_byte[0];
								2'h1: begin
									if (rx_byte == CMD_READ_BYTE) begin
										ack_q <= !busy_q && fifo_in_ready;
										rb_pend_q <= !busy_q && fifo_in_ready;
										accept_q <= !busy_q && fifo_in_ready;
									end else if (rx_byte == CMD_TRIPLET) begin
										ack_q <= !busy_q;
										trip_ok_q <= !busy_q;
										accept_q <= !busy_q;
									end else begin
										ack_q <= 1'b0;
									end
								end
								2'h2: ack_q <= trip_ok_q;
								2'h3: ack_q <= 1'b0;
							endcase
						end
					end
					if (scl_fall && bit_cnt_q == 4'h1 && byte_q == 2'h2 && trip_ok_q) begin
						trip_go_q <= 1'b1;
					end
					if (scl_fall && bit_cnt_q == 4'h8) begin
						i_state_q <= I_ACK;
						bit_cnt_q <= 4'h0;
						sda_oe_n_q <= !ack_q;
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						sda_oe_n_q <= 1'b1;
						byte_q <= (byte_q == 2'h3) ? 2'h3 : byte_q + 2'h1;
						i_state_q <= ack_q ? I_BITS : I_SKIP;
						rb_go_q <= rb_pend_q;
						rb_pend_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// Control register
	logic [2:0] ctrl_q;
	// Slot engine state
	swb_slot_t s_state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [2:0] idx_q;
	logic is_trip_q, od_q, wbit_q, owl_oe_n_q, pullup_q, push_q;
	logic sbr_q, tsb_q, dir_q, r0_q;
	logic [7:0] rb_sh_q;
	logic [CNT_W-1:0] slot_len, low_len, msr_len;
	logic last_slot, slot_end, sample_now;
	assign slot_len = tsel(od_q, SLOT_STD_CYC, SLOT_OD_CYC);
	assign low_len = wbit_q ? tsel(od_q, LOW1_STD_CYC, LOW1_OD_CYC)
		: tsel(od_q, LOW0_STD_CYC, LOW0_OD_CYC);
	assign msr_len = tsel(od_q, MSR_STD_CYC, MSR_OD_CYC);
	assign last_slot = idx_q == (is_trip_q ? LAST_SLOT_TRIP : LAST_SLOT_RB);
	assign slot_end = (s_state_q != S_IDLE) && (cnt_q == slot_len - 1'b1);
	assign sample_now = (s_state_q != S_IDLE) && (cnt_q == msr_len - 1'b1);

	// Slot sequencer: timing, drive and busy
	always_ff @(posedge clk) begin
		push_q <= 1'b0;
		if (!rst_n) begin
			s_state_q <= S_IDLE;
			cnt_q <= '0;
			idx_q <= 3'h0;
			is_trip_q <= 1'b0;
			od_q <= 1'b0;
			wbit_q <= 1'b1;
			owl_oe_n_q <= 1'b1;
			pullup_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			unique case (s_state_q)
				S_IDLE: begin
					if (rb_go_q || trip_go_q) begin
						s_state_q <= S_LOW;
						busy_q <= 1'b1;
						is_trip_q <= trip_go_q;
						od_q <= ctrl_q[CTRL_OD_BIT];
						idx_q <= 3'h0;
						cnt_q <= '0;
						wbit_q <= 1'b1;
						owl_oe_n_q <= 1'b0;
					end
				end
				S_LOW, S_HIGH: begin
					cnt_q <= cnt_q + 1'b1;
					if (s_state_q == S_LOW && cnt_q == low_len - 1'b1) begin
						// Release line; active pullup only, no strong
						s_state_q <= S_HIGH;
						owl_oe_n_q <= 1'b1;
						pullup_q <= ctrl_q[CTRL_APU_BIT];
					end
					if (slot_end) begin
						pullup_q <= 1'b0;
						if (last_slot) begin
							s_state_q <= S_IDLE;
							busy_q <= 1'b0;
							push_q <= !is_trip_q;
						end else begin
							s_state_q <= S_LOW;
							cnt_q <= '0;
							idx_q <= idx_q + 3'h1;
							owl_oe_n_q <= 1'b0;
							wbit_q <= (is_trip_q && idx_q == 3'h1) ? dir_q : 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Sample capture and result flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sbr_q <= 1'b0;
			tsb_q <= 1'b0;
			dir_q <= 1'b0;
			r0_q <= 1'b0;
			rb_sh_q <= 8'h00;
		end else if (sample_now) begin
			if (!is_trip_q) begin
				rb_sh_q <= {owl_s, rb_sh_q[7:1]};
			end else if (idx_q == 3'h0) begin
				sbr_q <= owl_s;
				r0_q <= owl_s;
			end else if (idx_q == 3'h1) begin
				// differ follows first; ones write one
				tsb_q <= owl_s;
				dir_q <= r0_q | (!owl_s & v_q);
			end
		end
	end

	// Result queue toward register port
	logic fifo_out_valid, fifo_pop;
	logic [7:0] fifo_out_data;
	assign fifo_pop = reg_rd && reg_addr == REG_RDATA;
	swb_fifo #(.WIDTH(8), .DEPTH(QDEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push_q),
		.in_ready(fifo_in_ready),
		.in_data(rb_sh_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// Register writes and read pointer
	logic rptr_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST;
			rptr_q <= RP_STATUS;
		end else begin
			if (reg_wr && reg_addr == REG_CTRL) begin
				ctrl_q <= reg_wdata[2:0];
			end
			// accept parks pointer, wins over write
			if (accept_q) begin
				rptr_q <= RP_STATUS;
			end else if (reg_wr && reg_addr == REG_RPTR) begin
				rptr_q <= reg_wdata[0];
			end
		end
	end

	// Register reads, answered one cycle later
	logic [7:0] status;
	assign status = {2'b00, !fifo_in_ready, fifo_out_valid, dir_q, tsb_q, sbr_q, busy_q};
	logic [7:0] rdata_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: rdata_q <= {5'h00, ctrl_q};
				REG_STATUS: rdata_q <= status;
				REG_RDATA: rdata_q <= fifo_out_valid ? fifo_out_data : 8'h00;
				REG_RPTR: rdata_q <= {7'h00, rptr_q};
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// Output drive: open-drain data always low when enabled
	assign sda_out = 1'b0;
	assign owl_out = 1'b0;
	assign sda_oe_n = sda_oe_n_q;
	assign owl_oe_n = owl_oe_n_q;
	assign owl_pullup = pullup_q;
	assign line_busy_flag = busy_q;
	assign reg_rdata = rdata_q;

	// Helper: busy length counter
	logic [15:0] busy_cyc_q;
	always_ff @(posedge clk) begin
		if (!rst_n || !busy_q) busy_cyc_q <= 16'h0001;
		else busy_cyc_q <= busy_cyc_q + 16'h0001;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_rb_refuse; (bit_cnt_q == 4'h7 && scl_rise && byte_q == 2'h1 && i_state_q == I_BITS
		&& rx_byte == CMD_READ_BYTE && busy_q) |=> !ack_q && !rb_pend_q; endproperty
	a_rb_refuse: assert property (p_rb_refuse) else $error("busy read-byte acked");
	property p_trip_refuse; (bit_cnt_q == 4'h7 && scl_rise && byte_q == 2'h1 && i_state_q == I_BITS
		&& rx_byte == CMD_TRIPLET && busy_q) |=> !ack_q && !trip_ok_q; endproperty
	a_trip_refuse: assert property (p_trip_refuse) else $error("busy triplet acked");
	property p_start; (rb_go_q || trip_go_q) && !busy_q |-> ##[1:3] !owl_oe_n_q; endproperty
	a_start: assert property (p_start) else $error("slot start too late");
	// Counter has stepped once past the last busy cycle, so look one cycle back
	property p_busy_len; $fell(busy_q)
		|-> ($past(busy_cyc_q) == 16'(slot_len) * (is_trip_q ? 16'd3 : 16'd8));
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_read_low; (s_state_q == S_LOW && (!is_trip_q || idx_q < 3'h2))
		|-> wbit_q && !owl_oe_n_q; endproperty
	a_read_low: assert property (p_read_low) else $error("read slot not write-one");
	property p_dir; (sample_now && is_trip_q && idx_q == 3'h1)
		|=> dir_q == (($past(r0_q) != $past(owl_s)) ? $past(r0_q) : ($past(owl_s) | v_q));
	endproperty
	a_dir: assert property (p_dir) else $error("direction choice wrong");
	property p_sbr; (sample_now && is_trip_q && idx_q == 3'h0) |=> sbr_q == $past(owl_s); endproperty
	a_sbr: assert property (p_sbr) else $error("single bit result not updated");
	property p_rptr; accept_q |=> rptr_q == RP_STATUS; endproperty
	a_rptr: assert property (p_rptr) else $error("read pointer not on status");
	property p_push; (slot_end && last_slot && !is_trip_q) |=> push_q ##1 !busy_q; endproperty
	a_push: assert property (p_push) else $error("read byte not stored");
	property p_nospu; !busy_q |-> !pullup_q; endproperty
	a_nospu: assert property (p_nospu) else $error("pullup after slots");

	property p_cv_rb; rb_go_q ##1 busy_q; endproperty
	c_cv_rb: cover property (p_cv_rb);
	property p_cv_trip; trip_go_q ##1 busy_q; endproperty
	c_cv_trip: cover property (p_cv_trip);
	property p_cv_pop; fifo_pop && fifo_out_valid; endproperty
	c_cv_pop: cover property (p_cv_pop);
endmodule : swb_core

// File: dv/swb_host_model.sv
// Purpose: Serial host model that sends write frames to the bridge
// Assumes: SDA is open drain with a pull-up, resolved in the bench
// Notes: Each SCL phase lasts four system clocks, so one bit takes 320 ns

`timescale 1ns/1ns

module swb_host_model (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	// Fall times of the last MS bit and of the last ack bit
	time t_msb;
	time t_ack;
	time t_fall;

	// Bus idles high; SCL stands still between frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		t_msb = 0;
		t_ack = 0;
		t_fall = 0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold

	// Start: SDA falls while SCL is high
	task automatic start();
		sda_drv <= 1'b0;
		hold(4);
		scl <= 1'b0;
		hold(1);
	endtask : start

	// Data moves one cycle after SCL falls, so it never races the fall
	task automatic send_bit(input logic b, output logic got);
		sda_drv <= b;
		hold(3);
		scl <= 1'b1;
		hold(4);
		got = sda;
		scl <= 1'b0;
		t_fall = $time;
		hold(1);
	endtask : send_bit

	// MS bit first, then the ack slot with SDA released
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			send_bit(d[i], g);
			if (i == 7) begin
				t_msb = t_fall;
			end
		end
		send_bit(1'b1, g);
		t_ack = t_fall;
		ack = ~g;
	endtask : send_byte

	// Stop: SDA rises while SCL is high
	task automatic stop();
		sda_drv <= 1'b0;
		hold(3);
		scl <= 1'b1;
		hold(4);
		sda_drv <= 1'b1;
		hold(4);
	endtask : stop
endmodule : swb_host_model

// File: dv/test_single_wire_read_byte_and_triplet.sv
// Purpose: Self-checking bench for the read-byte and triplet engine
// Assumes: Host model on the serial pins, a behavioural slave on the line
// Notes: Register reads are checked from a queue of expected values

`timescale 1ns/1ns

module test_single_wire_read_byte_and_triplet import swb_pkg::*;;
	localparam logic [6:0] SLV = 7'h2A;
	logic clk, rst_n, scl, sda_drv, sda_oe_n, owl_oe_n, owl_pullup, line_busy_flag;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rb;
	logic reg_wr, reg_rd, slv_pull, rd_d, busy_d, pu_seen, ans, r0, r1, v, ed;
	// Level the device drives while its enable is low
	logic sda_o, owl_o;
	// Open-drain wires with pull-ups
	wire logic sda_line = sda_drv & (sda_oe_n | sda_o);
	wire logic owl_line = (owl_oe_n | owl_o) & ~slv_pull;
	int err_count, n_compared, hold_cyc;
	logic [15:0] bcnt, busy_len;
	logic [11:0] lcnt;
	time t_act;
	logic [7:0] expq[$], mskq[$], dq[$];
	logic bitq[$];
	logic [11:0] lowq[$];

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	swb_core #(.SLAVE_ADDR(SLV)) u_dut (
		.clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_o),
		.sda_oe_n(sda_oe_n), .owl_in(owl_line), .owl_out(owl_o), .owl_oe_n(owl_oe_n),
		.owl_pullup(owl_pullup), .line_busy_flag(line_busy_flag), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	swb_host_model u_host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda_line));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("Counts: compared=%0d mismatches=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// One-cycle strobes with a gap, so no strobe is driven twice per step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		expq.push_back(e);
		mskq.push_back(m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd

	// Read data stand from the cycle after the strobe until the next read
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1) begin
			if (expq.size() > 0) begin
				check({24'h0, reg_rdata & mskq.pop_front()}, {24'h0, expq.pop_front()});
			end else begin
				check(32'h1, 32'h0);
			end
		end
	end

	// Busy length, low-pulse lengths, start time and pullup use
	always @(posedge clk) begin
		busy_d <= line_busy_flag;
		if (line_busy_flag === 1'b1) begin
			bcnt <= bcnt + 16'h1;
		end else if (bcnt != 0) begin
			busy_len <= bcnt;
			bcnt <= 16'h0;
		end
		// Busy rose one edge earlier than it is seen here
		if (line_busy_flag === 1'b1 && busy_d !== 1'b1) begin
			t_act <= $time - CLK_NS;
		end
		if (owl_oe_n === 1'b0) begin
			lcnt <= lcnt + 12'h1;
		end else if (lcnt != 0) begin
			lowq.push_back(lcnt);
			lcnt <= 12'h0;
		end
		if (owl_pullup === 1'b1) begin
			pu_seen <= 1'b1;
		end
	end

	// Slave answers zero by holding the line low past the sample point
	always @(negedge owl_line) begin
		if (slv_pull === 1'b0) begin
			ans = (bitq.size() > 0) ? bitq.pop_front() : 1'b1;
			if (!ans) begin
				slv_pull <= 1'b1;
				repeat (hold_cyc) @(posedge clk);
				slv_pull <= 1'b0;
			end
		end
	end

	task automatic cmd(input logic [7:0] code, input logic has_dir, input logic [7:0] dir,
		input logic ea, input logic ed2);
		logic a;
		u_host.start();
		u_host.send_byte({SLV, 1'b0}, a);
		check({31'h0, a}, 32'h1);
		u_host.send_byte(code, a);
		check({31'h0, a}, {31'h0, ea});
		if (has_dir) begin
			u_host.send_byte(dir, a);
			check({31'h0, a}, {31'h0, ed2});
		end
		u_host.stop();
	endtask : cmd

	// Bounded wait for the line to go idle
	task automatic wait_idle();
		int n;
		n = 0;
		while (line_busy_flag !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n < 20000}, 32'h1);
		repeat (2) @(posedge clk);
	endtask : wait_idle

	// Read-byte; optionally retry both commands while the line is busy
	task automatic run_rb(input logic [7:0] b, input logic [11:0] slot, input logic [11:0] low1,
		input logic rej);
		for (int i = 0; i < 8; i++) begin
			bitq.push_back(b[i]);
		end
		lowq.delete();
		wr(REG_RPTR, 8'h01);
		// Pointer must really have moved, else the park check below proves nothing
		rd(REG_RPTR, 8'h01, 8'h01);
		cmd(CMD_READ_BYTE, 1'b0, 8'h00, 1'b1, 1'b0);
		check({31'h0, (t_act - u_host.t_ack) <= START_MAX_PS / 1000}, 32'h1);
		rd(REG_RPTR, 8'h00, 8'h01);
		if (rej) begin
			cmd(CMD_READ_BYTE, 1'b0, 8'h00, 1'b0, 1'b0);
			cmd(CMD_TRIPLET, 1'b1, 8'h80, 1'b0, 1'b0);
		end
		wait_idle();
		check(busy_len, 8 * slot);
		check(lowq.size(), 8);
		foreach (lowq[i]) check(lowq[i], low1);
		dq.push_back(b);
	endtask : run_rb

	initial begin
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slv_pull = 1'b0;
		{rd_d, busy_d, pu_seen} = 3'h0;
		{err_count, n_compared, bcnt, lcnt, busy_len, t_act} = '0;
		hold_cyc = 625;
		void'($urandom(32'h6bc7));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values, then an unmapped index
		rd(REG_CTRL, 8'h00, 8'hFF);
		rd(REG_STATUS, 8'h00, 8'hFF);
		rd(REG_RDATA, 8'h00, 8'hFF);
		rd(REG_RPTR, 8'h00, 8'hFF);
		wr(4'hC, 8'($urandom));
		rd(4'hC, 8'h00, 8'hFF);
		// Standard speed, no active pullup
		wr(REG_CTRL, 8'h00);
		run_rb(8'($urandom), SLOT_STD_CYC, LOW1_STD_CYC, 1'b0);
		check({31'h0, pu_seen}, 32'h0);
		rd(REG_RDATA, dq.pop_front(), 8'hFF);
		// Fast speed, active and strong pullup enabled
		hold_cyc = 75;
		wr(REG_CTRL, 8'h07);
		for (int k = 0; k < 8; k++) begin
			{r0, r1, v} = 3'(k);
			ed = (r0 == r1) ? (r0 | v) : r0;
			bitq.push_back(r0);
			bitq.push_back(r1);
			lowq.delete();
			pu_seen <= 1'b0;
			cmd(CMD_TRIPLET, 1'b1, {v, 7'($urandom)}, 1'b1, 1'b1);
			check({31'h0, (t_act - u_host.t_msb) <= START_MAX_PS / 1000}, 32'h1);
			wait_idle();
			check(busy_len, 3 * SLOT_OD_CYC);
			check(lowq.size(), 3);
			check(lowq[2], ed ? LOW1_OD_CYC : LOW0_OD_CYC);
			rd(REG_STATUS, {4'h0, ed, r1, r0, 1'b0}, 8'h0F);
			check({31'h0, pu_seen & ~owl_pullup}, 32'h1);
		end
		// Fill the result queue until it refuses, then drain it
		for (int i = 0; i < 8; i++) begin
			run_rb(8'($urandom), SLOT_OD_CYC, LOW1_OD_CYC, i == 0);
		end
		rd(REG_STATUS, 8'h30, 8'h31);
		cmd(CMD_READ_BYTE, 1'b0, 8'h00, 1'b0, 1'b0);
		while (dq.size() > 0) begin
			rd(REG_RDATA, dq.pop_front(), 8'hFF);
		end
		rd(REG_RDATA, 8'h00, 8'hFF);
		rd(REG_STATUS, 8'h00, 8'h31);
		print_verdict();
	end

	// Watchdog sized well above the expected run
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		print_verdict();
	end
endmodule : test_single_wire_read_byte_and_triplet
